// *** logic/asq_pkg.sv ***
package asq_pkg;
    // ------------------------------------------------------------
    // qualifier types, fixed when the logic is built
    // ------------------------------------------------------------
    typedef enum {
        ASQ_CONTINUOUS,
        ASQ_CONDITIONAL,
        ASQ_START_STOP,
        ASQ_STATE_BASED
    } asq_mode_t;

    // acquisition sequencer states
    typedef enum {
        ASQ_IDLE,
        ASQ_ACQUIRE,
        ASQ_DONE
    } asq_state_t;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COND_TERMS = 8'h08;
    localparam logic [7:0] OFS_START_TERMS = 8'h0c;
    localparam logic [7:0] OFS_STOP_TERMS = 8'h10;
    localparam logic [7:0] OFS_TRIG_TERMS = 8'h14;
    localparam logic [7:0] OFS_ADV = 8'h18;

    // control register fields
    localparam int CTRL_ARM = 0;
    localparam int CTRL_QDIS = 1;
    localparam int CTRL_DISC = 2;
    localparam int CTRL_FORCE = 3;
    localparam int CTRL_SEL_LSB = 4;

    // combine selection codes
    localparam logic [1:0] SEL_AND = 2'h0;
    localparam logic [1:0] SEL_OR = 2'h1;
    localparam logic [1:0] SEL_ADV = 2'h2;

    // status register fields
    localparam int STAT_ACQ = 0;
    localparam int STAT_STORING = 1;
    localparam int STAT_TRIG = 2;
    localparam int STAT_OVF = 3;
    localparam int STAT_CNT_LSB = 16;

    // advanced register fields
    localparam int ADV_MASK_LSB = 0;
    localparam int ADV_VAL_LSB = 8;
    localparam int ADV_OP_LSB = 16;

    // per-signal term codes, three bits each
    localparam logic [2:0] TERM_DC = 3'h0;
    localparam logic [2:0] TERM_LOW = 3'h1;
    localparam logic [2:0] TERM_HIGH = 3'h2;
    localparam logic [2:0] TERM_FALL = 3'h3;
    localparam logic [2:0] TERM_RISE = 3'h4;
    localparam logic [2:0] TERM_EDGE = 3'h5;

    // advanced relational operators
    localparam logic [2:0] OP_LT = 3'h0;
    localparam logic [2:0] OP_LE = 3'h1;
    localparam logic [2:0] OP_EQ = 3'h2;
    localparam logic [2:0] OP_NE = 3'h3;
    localparam logic [2:0] OP_GT = 3'h4;
    localparam logic [2:0] OP_GE = 3'h5;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TERMS_RST = 32'h0000_0000;
endpackage

// *** logic/asq_qualifier.sv ***
// Contract
// - conditional mode writes only when condition true
// - each signal matched against one term
// - basic AND needs every term true
// - advanced condition uses relational operators
// - start/stop writes every cycle until stop
// - start while storing has no effect
// - start and stop together store one sample
// - forced trigger ends a starved acquisition
// - state-based stores nothing before store-start
// - store-stop pauses writing until restarted
// - store-start and store-stop together store one
// - mark stored samples following a pause
// - run-time disable forces continuous writing
// - qualifier type fixed at build time
// - sample continuously until trigger reached
// - trigger evaluated every acquiring cycle
// - continuous type writes every cycle
//
// Added by the designer: strobed register access and the placing of the registers.

// ------------------------------------------------------------
// sample fifo between qualifier and acquisition memory
// ------------------------------------------------------------
module asq_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];  // storage array
    logic [AW:0] wr_q;  // write pointer with wrap bit
    logic [AW:0] rd_q;  // read pointer with wrap bit
    logic out_valid_q;  // output stage holds a word
    logic [W-1:0] out_data_q;  // output stage data
    wire empty = (wr_q == rd_q);
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire push = in_valid && !full;
    // output stage refills whenever it is free or being drained
    wire load = !empty && (!out_valid_q || out_ready);

    assign in_ready = !full;
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    // array write, no reset needed on data
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // pointers and output stage
    always_ff @(posedge clock) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (load) begin
                rd_q <= rd_q + 1'b1;
                out_data_q <= mem_q[rd_q[AW-1:0]];
                out_valid_q <= 1'b1;
            end else if (out_ready) begin
                out_valid_q <= 1'b0;
            end
        end
    end
endmodule

// ------------------------------------------------------------
// storage qualifier top
// ------------------------------------------------------------
module asq_qualifier
    import asq_pkg::*;
#(
    parameter asq_mode_t QUAL_MODE = ASQ_CONDITIONAL,
    parameter int N = 8,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [asq_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic [N-1:0] probe,
    input wire logic store_start,
    input wire logic store_stop,
    output logic mem_valid,
    input wire logic mem_ready,
    output logic [N:0] mem_data,
    output logic acquiring,
    output logic triggered
);
    import asq_pkg::*;

    localparam int TW = 3 * N;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    // one signal against one basic term
    function automatic logic term_hit(input logic [2:0] code, input logic cur,
                                      input logic prev);
        case (code)
            TERM_DC: term_hit = 1'b1;
            TERM_LOW: term_hit = !cur;
            TERM_HIGH: term_hit = cur;
            TERM_FALL: term_hit = prev && !cur;
            TERM_RISE: term_hit = !prev && cur;
            TERM_EDGE: term_hit = prev != cur;
            default: term_hit = 1'b0;
        endcase
    endfunction

    // relational compare for the advanced condition
    function automatic logic adv_eval(input logic [2:0] op, input logic [N-1:0] a,
                                      input logic [N-1:0] b);
        case (op)
            OP_LT: adv_eval = a < b;
            OP_LE: adv_eval = a <= b;
            OP_EQ: adv_eval = a == b;
            OP_NE: adv_eval = a != b;
            OP_GT: adv_eval = a > b;
            OP_GE: adv_eval = a >= b;
            default: adv_eval = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic qdis_q;  // qualifier bypass
    logic disc_q;  // record discontinuities
    logic [1:0] sel_q;  // and / or / advanced
    logic [TW-1:0] cond_q;  // conditional terms
    logic [TW-1:0] start_q;  // start terms
    logic [TW-1:0] stop_q;  // stop terms
    logic [TW-1:0] trig_q;  // trigger terms
    logic [N-1:0] adv_mask_q;  // advanced operand mask
    logic [N-1:0] adv_val_q;  // advanced compare value
    logic [2:0] adv_op_q;  // advanced operator
    logic [N-1:0] prev_q;  // last cycle's probe sample
    logic storing_q;  // start/stop capture running
    logic gap_q;  // a sample was skipped since last store
    logic ovf_q;  // fifo refused a qualified sample
    logic [15:0] cnt_q;  // samples stored this acquisition
    logic [31:0] rdata_q;  // read data register
    asq_state_t state_q;  // acquisition sequencer

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire wr_ctrl = wr_stb && (addr == OFS_CTRL);
    wire arm = wr_ctrl && wdata[CTRL_ARM];
    wire force_trig = wr_ctrl && wdata[CTRL_FORCE];
    wire acq = (state_q == ASQ_ACQUIRE);

    // ------------------------------------------------------------
    // per-signal term evaluation, four term sets
    // ------------------------------------------------------------
    logic [N-1:0] cond_vec;
    logic [N-1:0] start_vec;
    logic [N-1:0] stop_vec;
    logic [N-1:0] trig_vec;
    logic [N-1:0] cond_care;  // signals whose conditional term is not don't care
    for (genvar i = 0; i < N; i++) begin : g_term
        // a don't-care signal must not satisfy an or on its own
        assign cond_care[i] = (cond_q[3*i +: 3] != TERM_DC);
        // edges use the registered previous sample
        assign cond_vec[i] = term_hit(cond_q[3*i +: 3], probe[i], prev_q[i]);
        assign start_vec[i] = term_hit(start_q[3*i +: 3], probe[i], prev_q[i]);
        assign stop_vec[i] = term_hit(stop_q[3*i +: 3], probe[i], prev_q[i]);
        assign trig_vec[i] = term_hit(trig_q[3*i +: 3], probe[i], prev_q[i]);
    end

    wire and_hit = &cond_vec;
    wire or_hit = |(cond_vec & cond_care);
    wire adv_hit = adv_eval(adv_op_q, probe & adv_mask_q, adv_val_q);
    wire cond_hit = (sel_q == SEL_OR) ? or_hit : (sel_q == SEL_ADV) ? adv_hit : and_hit;
    wire start_hit = &start_vec;
    wire stop_hit = &stop_vec;
    // trigger logic looks at every acquiring cycle, whatever the qualifier says
    wire trig_hit = acq && &trig_vec;

    // start/stop and state-based share one store latch with its own sources
    wire go = (QUAL_MODE == ASQ_STATE_BASED) ? store_start : start_hit;
    wire halt = (QUAL_MODE == ASQ_STATE_BASED) ? store_stop : stop_hit;
    // a start while already storing changes nothing
    wire store_now = storing_q || go;
    // the go cycle itself stores, so go with halt stores exactly one
    wire storing_d = store_now && !halt;

    // qualified write request; the build-time type picks the source
    wire want = qdis_q ? 1'b1 :
        (QUAL_MODE == ASQ_CONTINUOUS) ? 1'b1 :
        (QUAL_MODE == ASQ_CONDITIONAL) ? cond_hit : store_now;
    wire wr_req = acq && want;
    wire fifo_ready;
    // a full fifo refuses the store: the sample is dropped and counted as a gap
    wire push = wr_req && fifo_ready;
    wire mark = disc_q && gap_q;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [31:0] status_w = {cnt_q, 12'h000, ovf_q, triggered, storing_q, acq};
    wire [31:0] ctrl_w = {26'h0, sel_q, 1'b0, disc_q, qdis_q, 1'b0};
    wire [31:0] adv_w = {13'h0, adv_op_q, {(8 - N){1'b0}}, adv_val_q,
                         {(8 - N){1'b0}}, adv_mask_q};
    wire [31:0] rd_mux =
        (addr == OFS_CTRL) ? ctrl_w :
        (addr == OFS_STATUS) ? status_w :
        (addr == OFS_COND_TERMS) ? 32'(cond_q) :
        (addr == OFS_START_TERMS) ? 32'(start_q) :
        (addr == OFS_STOP_TERMS) ? 32'(stop_q) :
        (addr == OFS_TRIG_TERMS) ? 32'(trig_q) :
        (addr == OFS_ADV) ? adv_w : 32'h0000_0000;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // configuration registers, written by software only
    always_ff @(posedge clock) begin
        if (srst) begin
            qdis_q <= CTRL_RST[CTRL_QDIS];
            disc_q <= CTRL_RST[CTRL_DISC];
            sel_q <= CTRL_RST[CTRL_SEL_LSB +: 2];
            cond_q <= TERMS_RST[TW-1:0];
            start_q <= TERMS_RST[TW-1:0];
            stop_q <= TERMS_RST[TW-1:0];
            trig_q <= TERMS_RST[TW-1:0];
            adv_mask_q <= '0;
            adv_val_q <= '0;
            adv_op_q <= OP_EQ;
        end else if (wr_stb) begin
            if (addr == OFS_CTRL) begin
                qdis_q <= wdata[CTRL_QDIS];  // may change mid-run
                disc_q <= wdata[CTRL_DISC];
                sel_q <= wdata[CTRL_SEL_LSB +: 2];
            end
            if (addr == OFS_COND_TERMS) cond_q <= wdata[TW-1:0];
            if (addr == OFS_START_TERMS) start_q <= wdata[TW-1:0];
            if (addr == OFS_STOP_TERMS) stop_q <= wdata[TW-1:0];
            if (addr == OFS_TRIG_TERMS) trig_q <= wdata[TW-1:0];
            if (addr == OFS_ADV) begin
                adv_mask_q <= wdata[ADV_MASK_LSB +: N];
                adv_val_q <= wdata[ADV_VAL_LSB +: N];
                adv_op_q <= wdata[ADV_OP_LSB +: 3];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rd_stb ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // acquisition sequencer
    // ------------------------------------------------------------
    // arm starts a fresh run; trigger or a forced stop ends it
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ASQ_IDLE;
        end else begin
            case (state_q)
                ASQ_IDLE, ASQ_DONE: begin
                    if (arm) state_q <= ASQ_ACQUIRE;
                end
                ASQ_ACQUIRE: begin
                    // forced end rescues a run that qualification starved
                    if (trig_hit || force_trig) state_q <= ASQ_DONE;
                end
                default: state_q <= ASQ_IDLE;
            endcase
        end
    end

    // sample history and qualifier state
    always_ff @(posedge clock) begin
        if (srst) begin
            prev_q <= '0;
            storing_q <= 1'b0;
            gap_q <= 1'b0;
            ovf_q <= 1'b0;
            cnt_q <= 16'h0000;
        end else begin
            prev_q <= probe;
            if (arm) begin
                storing_q <= 1'b0;  // nothing stored until a start
                gap_q <= 1'b0;
                ovf_q <= 1'b0;
                cnt_q <= 16'h0000;
            end else if (acq) begin
                storing_q <= storing_d;
                gap_q <= !push;
                if (wr_req && !fifo_ready) ovf_q <= 1'b1;
                if (push) cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // output flags
    always_ff @(posedge clock) begin
        if (srst) begin
            acquiring <= 1'b0;
            triggered <= 1'b0;
        end else begin
            acquiring <= (state_q == ASQ_ACQUIRE) ? !(trig_hit || force_trig) : arm;
            if (arm) triggered <= 1'b0;
            else if (trig_hit || (acq && force_trig)) triggered <= 1'b1;
        end
    end

    assign rdata = rdata_q;

    // ------------------------------------------------------------
    // sample fifo toward acquisition memory
    // ------------------------------------------------------------
    asq_fifo #(.W(N + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .srst(srst),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data({mark, probe}),
        .out_valid(mem_valid),
        .out_ready(mem_ready),
        .out_data(mem_data)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_idle_start;
        acq && !storing_q && go && !halt;
    endsequence
    sequence s_both;
        (QUAL_MODE != ASQ_CONTINUOUS) && (QUAL_MODE != ASQ_CONDITIONAL) &&
            acq && !storing_q && go && halt && !qdis_q && fifo_ready;
    endsequence

    a_cond_write: assert property ((QUAL_MODE == ASQ_CONDITIONAL) && acq && !qdis_q |->
        (push == (cond_hit && fifo_ready))) else $error("cond write mismatch");
    a_and_all: assert property (push && (QUAL_MODE == ASQ_CONDITIONAL) && !qdis_q &&
        sel_q == SEL_AND |-> &cond_vec) else $error("and store without all terms");
    a_or_any: assert property (push && (QUAL_MODE == ASQ_CONDITIONAL) && !qdis_q &&
        sel_q == SEL_OR |-> |(cond_vec & cond_care))
        else $error("or store without any term");
    a_ss_run: assert property (s_idle_start ##1 (acq && !halt) |->
        storing_q && $past(storing_d)) else $error("start did not run");
    a_ss_both: assert property (s_both |-> push ##1 !storing_q)
        else $error("both not single");
    a_start_ignore: assert property (acq && storing_q && go && !halt |=> storing_q || !acq)
        else $error("repeat start changed state");
    a_arm_clear: assert property (arm |=> !storing_q && !gap_q && cnt_q == 16'h0000)
        else $error("arm did not clear");
    a_disable_all: assert property (acq && qdis_q && fifo_ready |-> push)
        else $error("bypass skipped sample");
    a_trig_end: assert property (trig_hit |=> state_q == ASQ_DONE && triggered && !acquiring)
        else $error("trigger did not end run");
    a_force_end: assert property (acq && force_trig |=> state_q == ASQ_DONE ##1 !acquiring)
        else $error("force did not end run");
    a_gap_mark: assert property (acq && !push ##1 push && disc_q |-> mark)
        else $error("gap not marked");
endmodule

// *** test/asq_user_model.sv ***
// ------------------------------------------------------------
// monitored user logic: a free running probe pattern
// ------------------------------------------------------------
module asq_user_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] st_a,
    input wire logic [7:0] st_b,
    input wire logic [7:0] sp_a,
    input wire logic [7:0] both,
    output logic [7:0] probe,
    output logic store_start,
    output logic store_stop
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q; // sample pattern, one step per clock
    logic [7:0] cnt_d;

    // a counter makes every stored sample name its own cycle
    assign cnt_d = cnt_q + 8'h01;
    assign probe = cnt_q;

    // store actions of the state flow, decoded from the pattern so that
    // the bench knows the exact cycle of each one
    assign store_start = (cnt_q == st_a) | (cnt_q == st_b) | (cnt_q == both);
    assign store_stop = (cnt_q == sp_a) | (cnt_q == both);

    // counter keeps running whether or not a run is armed
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// *** test/test_asq_qualifier.sv ***
module test_asq_qualifier;
    timeunit 1ns;
    timeprecision 1ns;
    import asq_pkg::*;

    // ------------------------------------------------------------
    // stimulus, wires and bookkeeping
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic mem_ready = 1'b0;
    int rdy_mode = 0; // 0 stalls every other cycle, 1 always ready, 2 never
    logic [31:0] rdata;
    logic [2:0] mv; // mem_valid of conditional, start/stop, state instances
    logic [8:0] md [3];
    logic acq;
    logic trg; // triggered flag of the conditional instance
    logic [7:0] probe;
    logic s_start, s_stop;
    logic [7:0] st_a = 8'h00, st_b = 8'h00, sp_a = 8'h00, both = 8'h00;
    int bad_count = 0;
    int total_checks = 0;
    logic [8:0] got_q [3][$]; // words taken by the memory side
    logic [7:0] acq_q [$]; // probe of every acquiring cycle

    always #10 clock = ~clock;

    asq_user_model i_user (.clock(clock), .srst(srst), .st_a(st_a), .st_b(st_b),
        .sp_a(sp_a), .both(both), .probe(probe), .store_start(s_start),
        .store_stop(s_stop));

    asq_qualifier #(.QUAL_MODE(ASQ_CONDITIONAL), .N(8), .FIFO_DEPTH(16)) i_dut (
        .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .probe(probe), .store_start(s_start),
        .store_stop(s_stop), .mem_valid(mv[0]), .mem_ready(mem_ready),
        .mem_data(md[0]), .acquiring(acq), .triggered(trg));
    asq_qualifier #(.QUAL_MODE(ASQ_START_STOP), .N(8), .FIFO_DEPTH(16)) i_ss (
        .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(), .probe(probe), .store_start(s_start),
        .store_stop(s_stop), .mem_valid(mv[1]), .mem_ready(mem_ready),
        .mem_data(md[1]), .acquiring(), .triggered());
    asq_qualifier #(.QUAL_MODE(ASQ_STATE_BASED), .N(8), .FIFO_DEPTH(16)) i_sb (
        .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(), .probe(probe), .store_start(s_start),
        .store_stop(s_stop), .mem_valid(mv[2]), .mem_ready(mem_ready),
        .mem_data(md[2]), .acquiring(), .triggered());

    // memory side; the stall pattern keeps the fifo partly full
    always @(posedge clock) begin
        mem_ready <= (rdy_mode == 1) | ((rdy_mode == 0) & ~mem_ready);
    end

    // record acquiring cycles and every word handed over
    always @(posedge clock) begin
        if (acq === 1'b1) acq_q.push_back(probe);
        for (int k = 0; k < 3; k++) begin
            if (mv[k] === 1'b1 && mem_ready === 1'b1) got_q[k].push_back(md[k]);
        end
    end

    // ------------------------------------------------------------
    // bus tasks and comparisons
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // expected storage condition of the conditional instance per test
    function automatic bit qual(input int sc, input logic [7:0] v, input logic [7:0] p);
        case (sc)
            0: return v[1:0] == 2'h3;
            1: return (v[0] & ~p[0]) | (~v[2] & p[2]);
            2: return ~v[3] & (v[4] ^ p[4]);
            3: return (v & 8'h0f) < 8'h04;
            default: return 1'b1;
        endcase
    endfunction

    // one armed run; all three instances share bus and probe
    task automatic run(input int sc, input logic [31:0] ctl, input logic [31:0] cond,
                       input logic [31:0] adv, input logic [31:0] trig, input bit frc);
        logic [31:0] s;
        logic [7:0] base, v;
        bit r_ss, r_sb;
        bit hit [3];
        bit gap [3];
        logic [8:0] e [3][$];
        int n;
        base = probe + 8'h10;
        st_a <= base;
        st_b <= base + 8'h02;
        sp_a <= base + 8'h04;
        both <= base + 8'h08;
        wr(OFS_COND_TERMS, cond);
        wr(OFS_ADV, adv);
        wr(OFS_TRIG_TERMS, trig);
        acq_q.delete();
        for (int k = 0; k < 3; k++) got_q[k].delete();
        wr(OFS_CTRL, ctl | 32'h1);
        if (frc) begin
            repeat (40) @(posedge clock);
            wr(OFS_CTRL, ctl | 32'h8);
        end
        n = 0;
        @(negedge clock);
        while (acq !== 1'b0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        repeat (50) @(posedge clock);
        r_ss = 0;
        r_sb = 0;
        for (int k = 0; k < 3; k++) gap[k] = 0;
        // reference walk over the acquiring cycles
        foreach (acq_q[i]) begin
            v = acq_q[i];
            hit[0] = ctl[CTRL_QDIS] | qual(sc, v, v - 8'h01);
            hit[1] = ctl[CTRL_QDIS] | r_ss | v[0];
            r_ss = (r_ss | v[0]) & ~(v[1] & v[2]);
            hit[2] = ctl[CTRL_QDIS] | r_sb | (v == base) | (v == base + 8'h02)
                | (v == base + 8'h08);
            r_sb = (r_sb | (v == base) | (v == base + 8'h02)) & (v != base + 8'h04)
                & (v != base + 8'h08);
            for (int k = 0; k < 3; k++) begin
                if (hit[k]) begin
                    e[k].push_back({gap[k], v});
                    gap[k] = 0;
                end else begin
                    gap[k] = 1;
                end
            end
        end
        for (int k = 0; k < 3; k++) begin
            check("stored words", e[k].size(), got_q[k].size());
            foreach (e[k][i]) begin
                if (i < got_q[k].size()) check("sample", e[k][i], got_q[k][i]);
            end
        end
        rd(OFS_STATUS, s);
        check("stored count", e[0].size(), s[31:16]);
        check("run ended", 32'h4, s & 32'hd);
        check("trigger pin", 1, trg);
        $display("test %0d done", sc);
    endtask

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_sim();
    end

    initial begin
        logic [31:0] s;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        // reset values, unmapped place, unused term bits
        rd(OFS_CTRL, s);
        check("ctrl reset", 32'h0, s);
        rd(OFS_ADV, s);
        check("adv reset", 32'h0002_0000, s);
        rd(8'h1c, s);
        check("unmapped", 32'h0, s);
        wr(OFS_COND_TERMS, 32'hffff_ffff);
        rd(OFS_COND_TERMS, s);
        check("term width", 32'h00ff_ffff, s);
        wr(OFS_CTRL, 32'h1e);
        rd(OFS_CTRL, s);
        check("ctrl pulses", 32'h16, s);
        // start on bit0 high, stop on bits 1 and 2 high
        wr(OFS_START_TERMS, 32'h2);
        wr(OFS_STOP_TERMS, 32'h90);
        $display("test registers done");
        run(0, 32'h04, 32'h12, 32'h0002_0000, 32'h6, 1);
        run(1, 32'h14, 32'hc4, 32'h0002_0000, 32'h6, 1);
        run(2, 32'h04, 32'h5200, 32'h0002_0000, 32'h6, 1);
        run(3, 32'h24, 32'h0, 32'h0000_040f, 32'h6, 1);
        rdy_mode = 1;
        run(4, 32'h06, 32'h12, 32'h0002_0000, 32'h0002_0000, 0);
        check("trigger cycle", 8'h20, acq_q[$] & 8'h3f);
        // memory stalled: the fifo fills and then refuses
        rdy_mode = 2;
        wr(OFS_TRIG_TERMS, 32'h6);
        repeat (4) @(posedge clock);
        for (int k = 0; k < 3; k++) got_q[k].delete();
        wr(OFS_CTRL, 32'h3);
        repeat (30) @(posedge clock);
        wr(OFS_CTRL, 32'ha);
        rd(OFS_STATUS, s);
        check("overflow", 32'hc, s & 32'hd);
        rdy_mode = 1;
        repeat (40) @(posedge clock);
        check("fifo depth", 1, got_q[0].size() >= 16 && got_q[0].size() <= 17);
        check("drained", 0, mv[0]);
        $display("test overflow done");
        end_sim();
    end
endmodule
